/* lcm_pkg.sv */
// Constants, types and register map of the light curtain monitor.
// Assumes one 250 MHz clock and a 32-bit Avalon-MM register bus.
//
// Behaviour
// - Channels must agree within skew window
// - Skew off: lone channel change faults
// - Skew setting off or 0.5-3.0 s steps
// - Skew window defaults to 3.0 s
// - Activation input optional, default not needed
// - Activation input switches monitor on/off
// - Restart modes automatic, manual, supervised
// - Restart mode defaults to manual
// - Restart input restarts in manual/supervised
// - Power-up check needs interruption plus restart
// - Power-up check at run and reactivation
// - Power-up check defaults to off
// - Release only while clear and conditions met
// - Both channels drop: release removed
// - Fault flag shows any error
// - Skew timer value always reported
// - Diag 0000, 2001, 2002 states
// - Diag 2003, 2004 restart edge waits
// - Diag 2005 one open, 200E power-up
// - Diag 8005 while released
// - Diag errors F001, F00B, F00E
// - Skew fault cleared by both dropping
package lcm_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned SKEW_STEP_MS = 500;
  localparam int unsigned TICKS_PER_STEP = SKEW_STEP_MS / TICK_MS;
  localparam int unsigned TICK_CYCLES_DEF = TICK_MS * 1000 * CLK_MHZ;

  // Register byte offsets
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_TIMER = 4'h8;

  // Config and status fields
  localparam int unsigned CFG_EXT_ACT_BIT = 0;
  localparam int unsigned CFG_MODE_LSB = 1;
  localparam int unsigned CFG_PUC_BIT = 3;
  localparam int unsigned CFG_SKEW_LSB = 4;
  localparam int unsigned CFG_RUN_BIT = 7;
  localparam int unsigned STAT_REL_BIT = 0;
  localparam int unsigned STAT_FAULT_BIT = 1;
  localparam int unsigned STAT_DIAG_LSB = 16;

  typedef enum logic [1:0] {
    LCM_AUTO_RESTART = 2'h0,
    LCM_MANUAL_RESTART = 2'h1,
    LCM_SUPERVISED_RESTART = 2'h2
  } lcm_mode_t;

  localparam logic [2:0] SKEW_OFF = 3'h0;
  localparam logic [2:0] SKEW_MAX = 3'h6;

  typedef struct packed {
    logic run;
    logic [2:0] skew_sel;
    logic power_up_check;
    lcm_mode_t mode;
    logic ext_act_needed;
  } lcm_cfg_t;

  localparam lcm_cfg_t CFG_RESET = '{
    run: 1'b1,
    skew_sel: SKEW_MAX,
    power_up_check: 1'b0,
    mode: LCM_MANUAL_RESTART,
    ext_act_needed: 1'b0
  };

  typedef struct packed {
    logic curtain_channel_one;
    logic curtain_channel_two;
    logic restart_request;
    logic block_activate;
  } lcm_pins_t;

  localparam logic [15:0] DG_NO_RELEASE = 16'h0000;
  localparam logic [15:0] DG_WAIT_FIRST = 16'h2001;
  localparam logic [15:0] DG_WAIT_SECOND = 16'h2002;
  localparam logic [15:0] DG_WAIT_RISE = 16'h2003;
  localparam logic [15:0] DG_WAIT_FALL = 16'h2004;
  localparam logic [15:0] DG_ONE_OPEN = 16'h2005;
  localparam logic [15:0] DG_POWER_UP = 16'h200e;
  localparam logic [15:0] DG_CLEAR = 16'h8005;
  localparam logic [15:0] DG_ERR_SKEW = 16'hf001;
  localparam logic [15:0] DG_ERR_START = 16'hf00b;
  localparam logic [15:0] DG_ERR_ONE = 16'hf00e;

endpackage : lcm_pkg

/* lcm_monitor.sv */
// Two-channel light curtain monitor with Avalon-MM register slave.
// Assumes curtain, restart and activation pins synchronous to sys_clk.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module lcm_monitor import lcm_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned TIMER_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire lcm_pins_t pins,
  output logic safe_release,
  output logic fault_flag,
  output logic [TIMER_W-1:0] skew_timer_value,
  output logic [15:0] diag_word
);

  if (TICK_CYCLES < 1 || TIMER_W > 32 ||
      TIMER_W < $clog2(int'(SKEW_MAX) * TICKS_PER_STEP + 1)) begin : g_bad_param
    $error("lcm_monitor: unsupported parameter values");
  end

  typedef enum logic [3:0] {
    ST_OFF, ST_POWER_UP, ST_WAIT_FIRST, ST_WAIT_SECOND, ST_WAIT_RISE,
    ST_WAIT_FALL, ST_RELEASE, ST_ONE_OPEN, ST_ERR_SKEW, ST_ERR_START, ST_ERR_ONE
  } lcm_state_t;

  function automatic logic [15:0] lcm_diag(input lcm_state_t s);
    case (s)
      ST_POWER_UP: lcm_diag = DG_POWER_UP;
      ST_WAIT_FIRST: lcm_diag = DG_WAIT_FIRST;
      ST_WAIT_SECOND: lcm_diag = DG_WAIT_SECOND;
      ST_WAIT_RISE: lcm_diag = DG_WAIT_RISE;
      ST_WAIT_FALL: lcm_diag = DG_WAIT_FALL;
      ST_RELEASE: lcm_diag = DG_CLEAR;
      ST_ONE_OPEN: lcm_diag = DG_ONE_OPEN;
      ST_ERR_SKEW: lcm_diag = DG_ERR_SKEW;
      ST_ERR_START: lcm_diag = DG_ERR_START;
      ST_ERR_ONE: lcm_diag = DG_ERR_ONE;
      default: lcm_diag = DG_NO_RELEASE;
    endcase
  endfunction : lcm_diag

  function automatic logic [TIMER_W-1:0] lcm_skew_limit(input logic [2:0] sel);
    lcm_skew_limit = TIMER_W'(sel * TICKS_PER_STEP);
  endfunction : lcm_skew_limit

  function automatic logic lcm_is_error(input lcm_state_t s);
    lcm_is_error = (s == ST_ERR_SKEW) || (s == ST_ERR_START) || (s == ST_ERR_ONE);
  endfunction : lcm_is_error

  // ---------------- Register slave ----------------
  lcm_cfg_t cfg, next_cfg;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic bus_req;
  logic bus_commit;
  logic [31:0] wdata_merged;

  assign bus_req = avs_read | avs_write;
  // Write lands on the edge where the master sees waitrequest low
  assign bus_commit = avs_write & ~avs_waitrequest;

  always_comb begin
    wdata_merged = {24'h000000, cfg};
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable[b]) begin
        wdata_merged[8*b +: 8] = avs_writedata[8*b +: 8];
      end
    end
  end

  always_comb begin
    next_cfg = cfg;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if (bus_req && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      if (avs_address == OFS_CONFIG) begin
        next_readdata = {24'h000000, cfg};
      end else if (avs_address == OFS_STATUS) begin
        next_readdata = {diag_word, 14'h0000, fault_flag, safe_release};
      end else if (avs_address == OFS_TIMER) begin
        next_readdata = 32'(skew_timer_value);
      end else begin
        next_readdata = 32'h00000000;
      end
    end
    if (bus_commit && avs_address == OFS_CONFIG) begin
      next_cfg.run = wdata_merged[CFG_RUN_BIT];
      next_cfg.ext_act_needed = wdata_merged[CFG_EXT_ACT_BIT];
      next_cfg.power_up_check = wdata_merged[CFG_PUC_BIT];
      // Out-of-range settings are refused; old value kept
      if (wdata_merged[CFG_SKEW_LSB +: 3] <= SKEW_MAX) begin
        next_cfg.skew_sel = wdata_merged[CFG_SKEW_LSB +: 3];
      end
      if (wdata_merged[CFG_MODE_LSB +: 2] <= LCM_SUPERVISED_RESTART) begin
        next_cfg.mode = lcm_mode_t'(wdata_merged[CFG_MODE_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg <= CFG_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      cfg <= next_cfg;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // ---------------- Tick prescaler ----------------
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_comb begin
    next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ---------------- Monitor state machine ----------------
  lcm_state_t state, next_state;
  logic [TIMER_W-1:0] next_timer;
  logic pu_pending, next_pu_pending;
  logic active, active_q, next_active_q;
  logic restart_q, next_restart_q;
  logic ch1, ch2, both_on, both_off, one_on;
  logic restart_rise;
  logic [TIMER_W-1:0] limit;
  logic next_release, next_fault;
  logic [15:0] next_diag;

  assign ch1 = pins.curtain_channel_one;
  assign ch2 = pins.curtain_channel_two;
  assign both_on = ch1 & ch2;
  assign both_off = ~ch1 & ~ch2;
  assign one_on = ch1 ^ ch2;
  assign restart_rise = pins.restart_request & ~restart_q;
  assign limit = lcm_skew_limit(cfg.skew_sel);
  // Run flag stands for the relay run state; activation pin optional
  assign active = cfg.run & (~cfg.ext_act_needed | pins.block_activate);

  always_comb begin
    next_state = state;
    next_timer = skew_timer_value;
    next_pu_pending = pu_pending;
    next_active_q = active;
    next_restart_q = pins.restart_request;
    if (!active) begin
      next_state = ST_OFF;
      next_timer = '0;
    end else begin
      case (state)
        ST_OFF: begin
          if (!active_q) begin
            // A check left over from an earlier activation must not linger
            next_pu_pending = cfg.power_up_check;
            // Stale restart held with curtain closed is not a valid start
            if (pins.restart_request && !both_off) begin
              next_state = ST_ERR_START;
            end else if (cfg.power_up_check) begin
              next_state = ST_POWER_UP;
              next_pu_pending = 1'b1;
            end else begin
              next_state = ST_WAIT_FIRST;
            end
          end
        end
        ST_POWER_UP: begin
          if (both_off) begin
            next_state = ST_WAIT_FIRST;
          end
        end
        ST_WAIT_FIRST: begin
          next_timer = '0;
          if (both_on) begin
            next_state = (cfg.mode == LCM_AUTO_RESTART && !pu_pending) ? ST_RELEASE
                                                                         : ST_WAIT_RISE;
          end else if (one_on) begin
            if (cfg.skew_sel == SKEW_OFF) begin
              next_state = ST_ERR_SKEW;
            end else begin
              next_state = ST_WAIT_SECOND;
            end
          end
        end
        ST_WAIT_SECOND: begin
          if (tick) begin
            next_timer = skew_timer_value + TIMER_W'(1);
          end
          if (both_on) begin
            next_state = (cfg.mode == LCM_AUTO_RESTART && !pu_pending) ? ST_RELEASE
                                                                         : ST_WAIT_RISE;
          end else if (both_off) begin
            next_state = ST_WAIT_FIRST;
          end else if (skew_timer_value >= limit) begin
            next_state = ST_ERR_SKEW;
          end
        end
        ST_WAIT_RISE: begin
          if (!both_on) begin
            next_state = ST_WAIT_FIRST;
          end else if (restart_rise) begin
            next_state = ST_WAIT_FALL;
          end
        end
        ST_WAIT_FALL: begin
          if (!both_on) begin
            next_state = ST_WAIT_FIRST;
          end else if (!pins.restart_request) begin
            next_state = ST_RELEASE;
            next_pu_pending = 1'b0;
          end
        end
        ST_RELEASE: begin
          next_pu_pending = 1'b0;
          if (both_off) begin
            next_state = ST_WAIT_FIRST;
          end else if (one_on) begin
            next_state = ST_ONE_OPEN;
          end
        end
        ST_ONE_OPEN: begin
          if (both_off) begin
            next_state = ST_WAIT_FIRST;
          end else if (both_on) begin
            next_state = ST_ERR_ONE;
          end
        end
        ST_ERR_SKEW, ST_ERR_ONE: begin
          if (both_off) begin
            next_state = ST_WAIT_FIRST;
            next_timer = '0;
          end
        end
        default: begin
          if (both_off && !pins.restart_request) begin
            next_state = ST_WAIT_FIRST;
          end
        end
      endcase
    end
    next_release = (next_state == ST_RELEASE);
    next_fault = lcm_is_error(next_state);
    next_diag = lcm_diag(next_state);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_OFF;
      skew_timer_value <= '0;
      pu_pending <= 1'b0;
      active_q <= 1'b0;
      restart_q <= 1'b0;
      safe_release <= 1'b0;
      fault_flag <= 1'b0;
      diag_word <= DG_NO_RELEASE;
    end else begin
      state <= next_state;
      skew_timer_value <= next_timer;
      pu_pending <= next_pu_pending;
      active_q <= next_active_q;
      restart_q <= next_restart_q;
      safe_release <= next_release;
      fault_flag <= next_fault;
      diag_word <= next_diag;
    end
  end

  // ---------------- Assertions ----------------
  property p_release_needs_both;
    @(posedge sys_clk) disable iff (rst) safe_release |-> $past(both_on);
  endproperty
  a_release_needs_both: assert property (p_release_needs_both)
    else $error("release while a channel was open");

  property p_drop_removes_release;
    @(posedge sys_clk) disable iff (rst) (safe_release && both_off) |=> !safe_release;
  endproperty
  a_drop_removes_release: assert property (p_drop_removes_release)
    else $error("release held after both channels dropped");

  property p_fault_matches_diag;
    @(posedge sys_clk) disable iff (rst) fault_flag == (diag_word[15:12] == 4'hf);
  endproperty
  a_fault_matches_diag: assert property (p_fault_matches_diag)
    else $error("fault flag and error code disagree");

  property p_release_diag;
    @(posedge sys_clk) disable iff (rst) safe_release == (diag_word == DG_CLEAR);
  endproperty
  a_release_diag: assert property (p_release_diag)
    else $error("release without clear code");

  property p_skew_expiry;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_WAIT_SECOND && one_on && active && skew_timer_value >= limit)
      |=> diag_word == DG_ERR_SKEW;
  endproperty
  a_skew_expiry: assert property (p_skew_expiry)
    else $error("expired skew window not flagged");

  property p_skew_off_lone;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_WAIT_FIRST && active && one_on && cfg.skew_sel == SKEW_OFF)
      |=> fault_flag && !safe_release;
  endproperty
  a_skew_off_lone: assert property (p_skew_off_lone)
    else $error("lone channel change not faulted with skew off");

  property p_skew_clear;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_ERR_SKEW && both_off && active) |=> diag_word == DG_WAIT_FIRST;
  endproperty
  a_skew_clear: assert property (p_skew_clear)
    else $error("skew fault not cleared by both channels dropping");

  property p_manual_pulse;
    @(posedge sys_clk) disable iff (rst)
      ($rose(safe_release) && cfg.mode != LCM_AUTO_RESTART) |-> $past(state) == ST_WAIT_FALL;
  endproperty
  a_manual_pulse: assert property (p_manual_pulse)
    else $error("manual release without restart pulse");

  property p_inactive_off;
    @(posedge sys_clk) disable iff (rst) !active |=> diag_word == DG_NO_RELEASE;
  endproperty
  a_inactive_off: assert property (p_inactive_off)
    else $error("monitor not off while deactivated");

  property p_bus_answer;
    @(posedge sys_clk) disable iff (rst)
      (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");

  property p_power_up_entry;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_OFF && active && !active_q && cfg.power_up_check &&
       !(pins.restart_request && !both_off)) |=> diag_word == DG_POWER_UP;
  endproperty
  a_power_up_entry: assert property (p_power_up_entry)
    else $error("power-up check not entered on activation");

  property p_restart_rise;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_WAIT_RISE && active && both_on && restart_rise)
      |=> diag_word == DG_WAIT_FALL;
  endproperty
  a_restart_rise: assert property (p_restart_rise)
    else $error("restart rise not taken");

  property p_timer_step;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_WAIT_SECOND && active && tick)
      |=> skew_timer_value == $past(skew_timer_value) + TIMER_W'(1);
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("skew timer did not advance on tick");

  property p_start_error;
    @(posedge sys_clk) disable iff (rst)
      (state == ST_OFF && active && !active_q && pins.restart_request && !both_off)
      |=> fault_flag && diag_word == DG_ERR_START;
  endproperty
  a_start_error: assert property (p_start_error)
    else $error("restart held at start-up not faulted");

  c_release: cover property (@(posedge sys_clk) disable iff (rst) $rose(safe_release));
  c_skew_err: cover property (@(posedge sys_clk) disable iff (rst) diag_word == DG_ERR_SKEW);
  c_one_err: cover property (@(posedge sys_clk) disable iff (rst) diag_word == DG_ERR_ONE);
  c_power_up: cover property (@(posedge sys_clk) disable iff (rst) diag_word == DG_POWER_UP);
  c_start_err: cover property (@(posedge sys_clk) disable iff (rst) diag_word == DG_ERR_START);

endmodule : lcm_monitor

/* lcm_curtain_model.sv */
// Behavioural two-channel curtain: switched outputs follow commanded states.
// Assumes the bench commands it on rising sys_clk edges.
`timescale 1ns/10ps
module lcm_curtain_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic want_one,
  input wire logic want_two,
  input wire logic [15:0] lag,
  output logic ch_one,
  output logic ch_two
);
  logic [15:0] wait_cnt;

  // Channel two trails by lag cycles; any 16-bit lag is reached before wait_cnt wraps
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ch_one <= 1'b0;
      ch_two <= 1'b0;
      wait_cnt <= 16'h0;
    end else begin
      ch_one <= want_one;
      if (want_two == ch_two) begin
        wait_cnt <= 16'h0;
      end else if (wait_cnt >= lag) begin
        ch_two <= want_two;
        wait_cnt <= 16'h0;
      end else begin
        wait_cnt <= wait_cnt + 16'h1;
      end
    end
  end
endmodule : lcm_curtain_model

/* light_curtain_monitor_tb_top.sv */
// Self-checking bench for the curtain monitor over its register bus and pins.
// Assumes a shortened tick of 4 clocks so 0.5 s steps are 200 clocks.
`timescale 1ns/10ps
module light_curtain_monitor_tb_top import lcm_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic want_one = 1'b0;
  logic want_two = 1'b0;
  logic [15:0] lag = 16'h0;
  logic ch_one;
  logic ch_two;
  logic rr = 1'b0;
  logic act = 1'b0;
  logic [3:0] be = 4'hf;
  lcm_pins_t pins_w;
  logic safe_release;
  logic fault_flag;
  logic [15:0] skew_timer_value;
  logic [15:0] diag_word;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  assign pins_w = {ch_one, ch_two, rr, act};

  lcm_monitor #(.TICK_CYCLES(4), .TIMER_W(16)) u_lcm_monitor (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins_w),
    .safe_release(safe_release), .fault_flag(fault_flag),
    .skew_timer_value(skew_timer_value), .diag_word(diag_word)
  );

  lcm_curtain_model u_lcm_curtain_model (
    .sys_clk(sys_clk), .rst(rst), .want_one(want_one), .want_two(want_two), .lag(lag),
    .ch_one(ch_one), .ch_two(ch_two)
  );

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Long ceiling: the whole sequence needs a few hundred clocks
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic cfg(input logic ext, input lcm_mode_t m, input logic puc, input logic [2:0] sk);
    bus(1'b1, OFS_CONFIG, {24'h0, 1'b1, sk, puc, m, ext});
  endtask : cfg

  task automatic see(input logic r, input logic f, input logic [15:0] d);
    repeat (3) @(posedge sys_clk);
    chk("safe_release", safe_release, r);
    chk("fault_flag", fault_flag, f);
    chk("diag_word", diag_word, d);
  endtask : see

  task automatic both(input logic v);
    want_one <= v;
    want_two <= v;
  endtask : both

  task automatic restart_walk();
    both(1'b1);
    see(1'b0, 1'b0, DG_WAIT_RISE);
    rr <= 1'b1;
    see(1'b0, 1'b0, DG_WAIT_FALL);
    rr <= 1'b0;
    see(1'b1, 1'b0, DG_CLEAR);
  endtask : restart_walk

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    see(1'b0, 1'b0, DG_WAIT_FIRST);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("config reset", rd, {24'h0, CFG_RESET});
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped read", rd, 32'h0);
    restart_walk();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd, {DG_CLEAR, 16'h1});
    both(1'b0);
    see(1'b0, 1'b0, DG_WAIT_FIRST);
    restart_walk();
    want_one <= 1'b0;
    see(1'b0, 1'b0, DG_ONE_OPEN);
    want_one <= 1'b1;
    see(1'b0, 1'b1, DG_ERR_ONE);
    both(1'b0);
    see(1'b0, 1'b0, DG_WAIT_FIRST);
    // Skew window of one step: 50 ticks of 4 clocks
    cfg(1'b0, LCM_MANUAL_RESTART, 1'b0, 3'h1);
    want_one <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("timer near 10", skew_timer_value >= 16'd9 && skew_timer_value <= 16'd11, 1'b1);
    bus(1'b0, OFS_TIMER, 32'h0);
    chk("timer register", rd >= 32'd9 && rd <= 32'd11, 1'b1);
    see(1'b0, 1'b0, DG_WAIT_SECOND);
    repeat (100) @(posedge sys_clk);
    see(1'b0, 1'b0, DG_WAIT_SECOND);
    repeat (70) @(posedge sys_clk);
    see(1'b0, 1'b1, DG_ERR_SKEW);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status fault", rd, {DG_ERR_SKEW, 16'h2});
    both(1'b0);
    see(1'b0, 1'b0, DG_WAIT_FIRST);
    lag <= 16'd20;
    both(1'b1);
    repeat (30) @(posedge sys_clk);
    see(1'b0, 1'b0, DG_WAIT_RISE);
    both(1'b0);
    lag <= 16'h0;
    cfg(1'b0, LCM_MANUAL_RESTART, 1'b0, SKEW_OFF);
    want_one <= 1'b1;
    see(1'b0, 1'b1, DG_ERR_SKEW);
    both(1'b0);
    see(1'b0, 1'b0, DG_WAIT_FIRST);
    bus(1'b1, OFS_CONFIG, 32'h000000f6);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("refused fields", rd, 32'h00000082);
    // Lane 0 masked: the whole config byte must stay as it was
    be = 4'he;
    bus(1'b1, OFS_CONFIG, 32'h000000ff);
    be = 4'hf;
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("masked lane", rd, 32'h00000082);
    cfg(1'b0, LCM_AUTO_RESTART, 1'b0, SKEW_MAX);
    both(1'b1);
    see(1'b1, 1'b0, DG_CLEAR);
    both(1'b0);
    cfg(1'b0, LCM_SUPERVISED_RESTART, 1'b0, SKEW_MAX);
    restart_walk();
    both(1'b0);
    // Stop then run with the start-up check on
    bus(1'b1, OFS_CONFIG, 32'h0);
    cfg(1'b0, LCM_AUTO_RESTART, 1'b1, SKEW_MAX);
    both(1'b1);
    see(1'b0, 1'b0, DG_POWER_UP);
    both(1'b0);
    repeat (3) @(posedge sys_clk);
    both(1'b1);
    repeat (3) @(posedge sys_clk);
    rr <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rr <= 1'b0;
    see(1'b1, 1'b0, DG_CLEAR);
    both(1'b0);
    cfg(1'b0, LCM_AUTO_RESTART, 1'b0, SKEW_MAX);
    cfg(1'b1, LCM_AUTO_RESTART, 1'b0, SKEW_MAX);
    both(1'b1);
    see(1'b0, 1'b0, DG_NO_RELEASE);
    act <= 1'b1;
    see(1'b1, 1'b0, DG_CLEAR);
    act <= 1'b0;
    see(1'b0, 1'b0, DG_NO_RELEASE);
    rr <= 1'b1;
    repeat (2) @(posedge sys_clk);
    act <= 1'b1;
    see(1'b0, 1'b1, DG_ERR_START);
    both(1'b0);
    rr <= 1'b0;
    see(1'b0, 1'b0, DG_WAIT_FIRST);
    give_verdict();
  end
endmodule : light_curtain_monitor_tb_top
